// ---- fpcq_regs.svh ----
// Constants for the partitioned flash command sequencer and query decode.
// Included by the design modules; definitions only.
`ifndef FPCQ_REGS_SVH
`define FPCQ_REGS_SVH
`define FPCQ_CMD_READ_ARRAY   8'hff
`define FPCQ_CMD_READ_STATUS  8'h70
`define FPCQ_CMD_READ_ID      8'h90
`define FPCQ_CMD_QUERY        8'h98
`define FPCQ_CMD_CLR_STATUS   8'h50
`define FPCQ_CMD_PGM_SETUP    8'h40
`define FPCQ_CMD_ERASE_SETUP  8'h20
`define FPCQ_CMD_ERASE_CONF   8'hd0
`define FPCQ_CMD_SUSPEND      8'hb0
`define FPCQ_CMD_RESUME       8'hd0
`define FPCQ_CMD_LOCK_SETUP   8'h60
`define FPCQ_CMD_LOCK_CONF    8'h01
`define FPCQ_CMD_UNLOCK_CONF  8'hd0
`define FPCQ_CMD_LDOWN_CONF   8'h2f
`define FPCQ_CMD_CR_CONF      8'h03
`define FPCQ_CMD_OTP_SETUP    8'hc0
`define FPCQ_CMD_EFP_SETUP    8'h30
`define FPCQ_CMD_EFP_CONF     8'hd0
`define FPCQ_SR_READY_BIT     7
`define FPCQ_SR_EFP_BIT       0
`define FPCQ_SR_ERR_MASK      8'h3a
`define FPCQ_SR_RESET         8'h80
`define FPCQ_QRY_BASE         8'h10
`define FPCQ_QRY_Q            8'h51
`define FPCQ_QRY_R            8'h52
`define FPCQ_QRY_Y            8'h59
`define FPCQ_QRY_HIGH_BYTE    8'h00
`define FPCQ_OP_CYCLES        16'd64
`define FPCQ_EFP_WORD_CYCLES  16'd4
`endif

// ---- fpcq_pkg.sv ----
// Types used only by the command sequencer; its helpers do not import them.
// Assumes fpcq_regs.svh is available on the include path.
package fpcq_pkg;
  typedef enum logic [1:0] {OUT_ARRAY, OUT_STATUS, OUT_QUERY} fpcq_out_t;
  typedef enum logic [3:0] {
    WS_READY, WS_LOCK_SETUP, WS_OTP_SETUP, WS_OTP_BUSY, WS_PGM_SETUP, WS_PGM_BUSY,
    WS_PGM_SUSP, WS_ERS_SETUP, WS_ERS_BUSY, WS_ERS_SUSP, WS_PIES_SETUP, WS_PIES_BUSY,
    WS_PIES_SUSP, WS_LOCK_IES, WS_EFP_SETUP, WS_EFP_BUSY
  } fpcq_wsm_t;
endpackage

// ---- fpcq_query_rom.sv ----
// Query database lookup: word offset to 16-bit data word.
// Purely combinational; the caller registers the result.
`timescale 1ns/10ps
`include "fpcq_regs.svh"
module fpcq_query_rom (
  input  wire logic [7:0]  offset,
  output logic      [15:0] word
);
  logic [7:0] low_data_lanes;
  always_comb begin
    // Multi-byte fields are stored low byte at the lower offset
    case (offset)
      `FPCQ_QRY_BASE:        low_data_lanes = `FPCQ_QRY_Q;
      `FPCQ_QRY_BASE + 8'h1: low_data_lanes = `FPCQ_QRY_R;
      `FPCQ_QRY_BASE + 8'h2: low_data_lanes = `FPCQ_QRY_Y;
      8'h13:                 low_data_lanes = 8'h03;
      8'h14:                 low_data_lanes = 8'h00;
      8'h15:                 low_data_lanes = 8'h39;
      8'h16:                 low_data_lanes = 8'h00;
      default:               low_data_lanes = 8'h00;
    endcase
    word = {`FPCQ_QRY_HIGH_BYTE, low_data_lanes};
  end
endmodule

// ---- fpcq_op_timer.sv ----
// Operation timer: counts a busy operation down and pulses when done.
// One clock; start is a one-cycle pulse, pause holds the count.
`timescale 1ns/10ps
`include "fpcq_regs.svh"
module fpcq_op_timer (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        start,
  input  wire logic [15:0] cycles,
  input  wire logic        pause,
  output logic             done
);
  typedef struct packed {logic [15:0] cnt; logic run; logic done;} fpcq_tmr_t;
  fpcq_tmr_t s_r, s_nxt;
  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    if (start) begin
      s_nxt.cnt = cycles;
      s_nxt.run = 1'b1;
    end else if (s_r.run && !pause) begin
      if (s_r.cnt <= 16'd1) begin
        s_nxt.run = 1'b0;
        s_nxt.done = 1'b1;
      end else begin
        s_nxt.cnt = s_r.cnt - 16'd1;
      end
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) s_r <= '0;
    else s_r <= s_nxt;
  end
  assign done = s_r.done;
endmodule

// ---- fpcq_top.sv ----
// Command sequencer and per-partition read mode of a partitioned flash.
// Assumes bus writes and reads arrive as one-cycle strobes synchronous to REF_CLK.
`timescale 1ns/10ps
`include "fpcq_regs.svh"
module fpcq_top
  import fpcq_pkg::*;
#(
  parameter int PART_BITS = 3,
  parameter int ADDR_BITS = 22
) (
  input  wire logic                 REF_CLK,
  input  wire logic                 RST,
  input  wire logic                 WR_STB,
  input  wire logic                 RD_STB,
  input  wire logic [ADDR_BITS-1:0] ADDR,
  input  wire logic [15:0]          WR_DATA,
  input  wire logic [15:0]          ARRAY_DATA,
  input  wire logic [7:0]           ERR_SET,
  output logic      [15:0]          RD_DATA,
  output logic                      RD_VALID,
  output logic      [7:0]           STATUS,
  output logic                      BUSY,
  output logic                      PGM_WORD_STB,
  output logic      [15:0]          PGM_WORD
);
  localparam int NPART = 1 << PART_BITS;

  typedef struct packed {
    fpcq_wsm_t              write_state_machine;
    fpcq_out_t [NPART-1:0]  outst;
    logic [PART_BITS-1:0]   setup_part;
    logic [PART_BITS-1:0]   busy_part;
    logic [ADDR_BITS-1:0]   efp_blk;
    logic [7:0]             errs;
    logic                   efp_bit0;
    logic [15:0]            rd_data;
    logic                   rd_valid;
    logic                   pgm_stb;
    logic [15:0]            pgm_word;
    logic                   tmr_start;
    logic [15:0]            tmr_cycles;
    logic                   ign_next;
    logic [7:0]             status;
    logic                   busy;
  } fpcq_state_t;

  fpcq_state_t s_r, s_nxt;
  logic        op_done;
  logic [15:0] query_word;
  logic [7:0]  cmd;
  logic [PART_BITS-1:0] wpart, rpart;
  logic        wsm_active;
  logic        wsm_suspended;
  logic [7:0]  status_byte;

  function automatic logic [PART_BITS-1:0] part_of(input logic [ADDR_BITS-1:0] a);
    part_of = a[ADDR_BITS-1 -: PART_BITS];
  endfunction

  function automatic logic is_active(input fpcq_wsm_t w);
    is_active = (w == WS_PGM_BUSY) || (w == WS_ERS_BUSY) || (w == WS_OTP_BUSY) ||
                (w == WS_PIES_BUSY) || (w == WS_EFP_BUSY);
  endfunction

  function automatic logic is_setup_code(input logic [7:0] c);
    is_setup_code = (c == `FPCQ_CMD_PGM_SETUP) || (c == `FPCQ_CMD_ERASE_SETUP) ||
                    (c == `FPCQ_CMD_LOCK_SETUP) || (c == `FPCQ_CMD_OTP_SETUP) ||
                    (c == `FPCQ_CMD_EFP_SETUP);
  endfunction

  assign cmd   = WR_DATA[7:0];
  assign wpart = part_of(ADDR);
  assign rpart = part_of(ADDR);
  assign wsm_active = is_active(s_r.write_state_machine);
  assign wsm_suspended = (s_r.write_state_machine == WS_PGM_SUSP) || (s_r.write_state_machine == WS_ERS_SUSP) ||
                         (s_r.write_state_machine == WS_PIES_SUSP);
  assign status_byte = {~wsm_active, s_r.errs[6:1], s_r.efp_bit0};

  fpcq_query_rom u_rom (
    .offset (ADDR[7:0]),
    .word   (query_word)
  );

  fpcq_op_timer u_tmr (
    .clk    (REF_CLK),
    .rst    (RST),
    .start  (s_r.tmr_start),
    .cycles (s_r.tmr_cycles),
    .pause  (wsm_suspended),
    .done   (op_done)
  );

  always_comb begin
    s_nxt = s_r;
    s_nxt.rd_valid  = 1'b0;
    s_nxt.pgm_stb   = 1'b0;
    s_nxt.tmr_start = 1'b0;
    s_nxt.errs = s_r.errs | ERR_SET;
    if (op_done) begin
      case (s_r.write_state_machine)
        WS_PIES_BUSY: s_nxt.write_state_machine = WS_ERS_SUSP;
        WS_EFP_BUSY:  s_nxt.efp_bit0 = 1'b0;
        default:      s_nxt.write_state_machine = WS_READY;
      endcase
    end
    if (WR_STB && s_r.ign_next) begin
      // Second cycle of a refused two-cycle command is swallowed whole
      s_nxt.ign_next = 1'b0;
    end else if (WR_STB) begin
      // Machine transitions depend on its own state and the command, never on a partition's read mode
      case (s_r.write_state_machine)
        WS_READY, WS_ERS_SUSP: begin
          if (cmd == `FPCQ_CMD_READ_ARRAY) s_nxt.outst[wpart] = OUT_ARRAY;
          else if (cmd == `FPCQ_CMD_READ_STATUS) s_nxt.outst[wpart] = OUT_STATUS;
          else if (cmd == `FPCQ_CMD_READ_ID || cmd == `FPCQ_CMD_QUERY)
            s_nxt.outst[wpart] = OUT_QUERY;
          else if (cmd == `FPCQ_CMD_CLR_STATUS && s_r.write_state_machine == WS_READY)
            s_nxt.errs = ERR_SET;
          else if (cmd == `FPCQ_CMD_RESUME && s_r.write_state_machine == WS_ERS_SUSP) begin
            s_nxt.write_state_machine = WS_ERS_BUSY;
            // One shared timer: a nested program may have reused it, so restart
            s_nxt.tmr_start = 1'b1;
            s_nxt.tmr_cycles = `FPCQ_OP_CYCLES;
            s_nxt.outst[wpart] = OUT_STATUS;
          end else if (is_setup_code(cmd)) begin
            s_nxt.setup_part = wpart;
            s_nxt.outst[wpart] = OUT_STATUS;
            if (s_r.write_state_machine == WS_ERS_SUSP) begin
              // Only program, lock and configuration allowed in erase suspend
              if (cmd == `FPCQ_CMD_PGM_SETUP) s_nxt.write_state_machine = WS_PIES_SETUP;
              else if (cmd == `FPCQ_CMD_LOCK_SETUP) s_nxt.write_state_machine = WS_LOCK_IES;
              else begin
                s_nxt.outst[wpart] = s_r.outst[wpart];
                s_nxt.ign_next = 1'b1;
              end
            end else begin
              case (cmd)
                `FPCQ_CMD_PGM_SETUP:   s_nxt.write_state_machine = WS_PGM_SETUP;
                `FPCQ_CMD_ERASE_SETUP: s_nxt.write_state_machine = WS_ERS_SETUP;
                `FPCQ_CMD_LOCK_SETUP:  s_nxt.write_state_machine = WS_LOCK_SETUP;
                `FPCQ_CMD_OTP_SETUP:   s_nxt.write_state_machine = WS_OTP_SETUP;
                default:               s_nxt.write_state_machine = WS_EFP_SETUP;
              endcase
            end
          end
        end
        WS_PGM_SETUP, WS_PIES_SETUP, WS_OTP_SETUP: begin
          // Second cycle decides the active partition; both show status
          s_nxt.outst[wpart] = OUT_STATUS;
          s_nxt.busy_part = wpart;
          s_nxt.pgm_stb   = 1'b1;
          s_nxt.pgm_word  = WR_DATA;
          s_nxt.tmr_start = 1'b1;
          s_nxt.tmr_cycles = `FPCQ_OP_CYCLES;
          if (s_r.write_state_machine == WS_PGM_SETUP) s_nxt.write_state_machine = WS_PGM_BUSY;
          else if (s_r.write_state_machine == WS_PIES_SETUP) s_nxt.write_state_machine = WS_PIES_BUSY;
          else s_nxt.write_state_machine = WS_OTP_BUSY;
        end
        WS_ERS_SETUP: begin
          s_nxt.outst[wpart] = OUT_STATUS;
          s_nxt.busy_part = wpart;
          if (cmd == `FPCQ_CMD_ERASE_CONF) begin
            s_nxt.write_state_machine = WS_ERS_BUSY;
            s_nxt.tmr_start = 1'b1;
            s_nxt.tmr_cycles = `FPCQ_OP_CYCLES;
          end else begin
            s_nxt.write_state_machine = WS_READY;
            s_nxt.errs[5:4] = 2'b11;
          end
        end
        WS_LOCK_SETUP, WS_LOCK_IES: begin
          // Confirm performs the operation then returns to ready, or to erase suspend from WS_LOCK_IES
          s_nxt.outst[wpart] = OUT_STATUS;
          s_nxt.write_state_machine = (s_r.write_state_machine == WS_LOCK_IES) ? WS_ERS_SUSP : WS_READY;
          if (!(cmd == `FPCQ_CMD_LOCK_CONF || cmd == `FPCQ_CMD_UNLOCK_CONF ||
                cmd == `FPCQ_CMD_LDOWN_CONF || cmd == `FPCQ_CMD_CR_CONF))
            s_nxt.errs[5:4] = 2'b11;
        end
        WS_EFP_SETUP: begin
          s_nxt.outst[wpart] = OUT_STATUS;
          if (cmd == `FPCQ_CMD_EFP_CONF) begin
            s_nxt.write_state_machine = WS_EFP_BUSY;
            s_nxt.efp_blk = ADDR;
            s_nxt.efp_bit0 = 1'b0;
          end else begin
            s_nxt.write_state_machine = WS_READY;
            s_nxt.errs[5:4] = 2'b11;
          end
        end
        WS_EFP_BUSY: begin
          // Any code to the confirmed block's partition is data while bit zero is clear; other partitions end the mode
          if (part_of(ADDR) != part_of(s_r.efp_blk)) begin
            s_nxt.write_state_machine = WS_READY;
          end else if (!s_r.efp_bit0) begin
            s_nxt.efp_bit0  = 1'b1;
            s_nxt.pgm_stb   = 1'b1;
            s_nxt.pgm_word  = WR_DATA;
            s_nxt.tmr_start = 1'b1;
            s_nxt.tmr_cycles = `FPCQ_EFP_WORD_CYCLES;
          end
        end
        WS_PGM_BUSY, WS_ERS_BUSY, WS_PIES_BUSY, WS_OTP_BUSY: begin
          // Active machine: two-cycle commands fall away, reads still change mode
          if (cmd == `FPCQ_CMD_SUSPEND && s_r.write_state_machine != WS_OTP_BUSY) begin
            if (s_r.write_state_machine == WS_PGM_BUSY) s_nxt.write_state_machine = WS_PGM_SUSP;
            else if (s_r.write_state_machine == WS_ERS_BUSY) s_nxt.write_state_machine = WS_ERS_SUSP;
            else s_nxt.write_state_machine = WS_PIES_SUSP;
          end else if (is_setup_code(cmd)) s_nxt.ign_next = 1'b1;
          else if (cmd == `FPCQ_CMD_READ_ARRAY) s_nxt.outst[wpart] = OUT_ARRAY;
          else if (cmd == `FPCQ_CMD_READ_STATUS) s_nxt.outst[wpart] = OUT_STATUS;
          else if (cmd == `FPCQ_CMD_READ_ID || cmd == `FPCQ_CMD_QUERY)
            s_nxt.outst[wpart] = OUT_QUERY;
        end
        WS_PGM_SUSP, WS_PIES_SUSP: begin
          // Program suspend: every two-cycle command is ignored
          if (cmd == `FPCQ_CMD_RESUME)
            s_nxt.write_state_machine = (s_r.write_state_machine == WS_PGM_SUSP) ? WS_PGM_BUSY : WS_PIES_BUSY;
          else if (is_setup_code(cmd)) s_nxt.ign_next = 1'b1;
          else if (cmd == `FPCQ_CMD_READ_ARRAY) s_nxt.outst[wpart] = OUT_ARRAY;
          else if (cmd == `FPCQ_CMD_READ_STATUS) s_nxt.outst[wpart] = OUT_STATUS;
          else if (cmd == `FPCQ_CMD_READ_ID || cmd == `FPCQ_CMD_QUERY)
            s_nxt.outst[wpart] = OUT_QUERY;
        end
        default: s_nxt.write_state_machine = WS_READY;
      endcase
    end
    if (RD_STB) begin
      s_nxt.rd_valid = 1'b1;
      // Mode is looked up for the partition being read
      case (s_r.outst[rpart])
        OUT_STATUS: s_nxt.rd_data = {8'h00, status_byte};
        OUT_QUERY:  s_nxt.rd_data = query_word;
        default:    s_nxt.rd_data = ARRAY_DATA;
      endcase
    end
    // Status and busy are registered from the next state so they show no lag
    s_nxt.status = {~is_active(s_nxt.write_state_machine), s_nxt.errs[6:1], s_nxt.efp_bit0};
    s_nxt.busy   = is_active(s_nxt.write_state_machine);
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      s_r <= '0;
      s_r.write_state_machine <= WS_READY;
      s_r.status <= `FPCQ_SR_RESET;
      for (int i = 0; i < NPART; i++) s_r.outst[i] <= OUT_ARRAY;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign RD_DATA      = s_r.rd_data;
  assign RD_VALID     = s_r.rd_valid;
  assign STATUS       = s_r.status;
  assign BUSY         = s_r.busy;
  assign PGM_WORD_STB = s_r.pgm_stb;
  assign PGM_WORD     = s_r.pgm_word;

  pending_ignore_a: assert property (@(posedge REF_CLK) disable iff (RST)
    (WR_STB && wsm_active && is_setup_code(cmd)) |=> s_r.write_state_machine != WS_READY || $past(op_done))
    else $error("Setup accepted while machine active");
  clr_blocked_a: assert property (@(posedge REF_CLK) disable iff (RST)
    (WR_STB && cmd == `FPCQ_CMD_CLR_STATUS && wsm_suspended && s_r.errs[4])
    |=> s_r.errs[4])
    else $error("Clear status acted during suspend");
  query_str_a: assert property (@(posedge REF_CLK) disable iff (RST)
    (RD_STB && s_r.outst[rpart] == OUT_QUERY && ADDR[7:0] == 8'h10 && !WR_STB)
    |=> RD_DATA == 16'h0051)
    else $error("Query string byte wrong");
  efp_gate_a: assert property (@(posedge REF_CLK) disable iff (RST)
    (WR_STB && s_r.write_state_machine == WS_EFP_BUSY && s_r.efp_bit0) |=> !PGM_WORD_STB)
    else $error("Factory data taken while bit zero set");
  lock_ready_a: assert property (@(posedge REF_CLK) disable iff (RST)
    (WR_STB && s_r.write_state_machine == WS_LOCK_SETUP) |=> s_r.write_state_machine == WS_READY)
    else $error("Lock confirm did not return ready");
  psusp_ign_a: assert property (@(posedge REF_CLK) disable iff (RST)
    (WR_STB && s_r.write_state_machine == WS_PGM_SUSP && cmd != `FPCQ_CMD_RESUME)
    |=> s_r.write_state_machine == WS_PGM_SUSP)
    else $error("Command accepted in program suspend");
  esusp_otp_a: assert property (@(posedge REF_CLK) disable iff (RST)
    (WR_STB && s_r.write_state_machine == WS_ERS_SUSP && cmd == `FPCQ_CMD_OTP_SETUP)
    |=> s_r.write_state_machine == WS_ERS_SUSP)
    else $error("Setup accepted in erase suspend");
  split_status_a: assert property (@(posedge REF_CLK) disable iff (RST)
    (WR_STB && s_r.write_state_machine == WS_PGM_SETUP) |=> s_r.outst[$past(wpart)] == OUT_STATUS)
    else $error("Second cycle partition not in status");
endmodule

// ---- fpcq_host.sv ----
// Host model: issues bus writes and reads to the flash command sequencer.
// Assumes one clock; every request is raised and dropped on a falling edge.
`timescale 1ns/10ps
module fpcq_host (
  input  wire logic        clk,
  input  wire logic [7:0]  status,
  output logic             wr_stb,
  output logic             rd_stb,
  output logic      [21:0] addr,
  output logic      [15:0] wr_data
);
  initial begin
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    addr = 22'h0;
    wr_data = 16'h0;
  end

  // Released lines show the inverse so that stale values never look valid
  task automatic wr(input int p, input logic [15:0] d);
    @(negedge clk);
    wr_stb = 1'b1;
    addr = {p[2:0], 19'h0};
    wr_data = d;
    @(negedge clk);
    wr_stb = 1'b0;
    addr = ~addr;
    wr_data = ~wr_data;
  endtask

  task automatic rd(input int p, input int off);
    @(negedge clk);
    rd_stb = 1'b1;
    addr = {p[2:0], 11'h0, off[7:0]};
    @(negedge clk);
    rd_stb = 1'b0;
    addr = ~addr;
  endtask

  task automatic cmd2(input int p, input logic [15:0] c, input logic [15:0] d);
    wr(p, c);
    wr(p, d);
  endtask

  // Bounded wait so a stuck flag cannot hang the host
  task automatic efp_word(input int p, input logic [15:0] d);
    int n;
    n = 0;
    while (status[0] !== 1'b0 && n < 100) begin
      @(negedge clk);
      n++;
    end
    wr(p, d);
  endtask
endmodule

// ---- flash_partition_cmd_query_tb.sv ----
// Self-checking bench for the partitioned flash command sequencer.
// Assumes fpcq_host drives the bus; partition modes and status are modelled here.
`timescale 1ns/10ps
module flash_partition_cmd_query_tb;
  logic        clk, rst, wr_stb, rd_stb, rd_valid, busy, pgm_stb;
  logic [21:0] addr;
  logic [15:0] wr_data, array_data, rd_data, pgm_word, d;
  logic [7:0]  err_set, status;
  int          n_fail = 0, cmp_count = 0, sr = 'h80;
  int          mode [8];
  logic [15:0] pq [$];
  logic [7:0]  qry [11] = '{8'h51, 8'h52, 8'h59, 8'h03, 8'h00, 8'h39, 8'h00, 8'h00,
                           8'h00, 8'h00, 8'h00};
  logic [15:0] conf [4] = '{16'h01, 16'hd0, 16'h2f, 16'h03};

  fpcq_top dut (.REF_CLK(clk), .RST(rst), .WR_STB(wr_stb), .RD_STB(rd_stb), .ADDR(addr),
    .WR_DATA(wr_data), .ARRAY_DATA(array_data), .ERR_SET(err_set), .RD_DATA(rd_data),
    .RD_VALID(rd_valid), .STATUS(status), .BUSY(busy), .PGM_WORD_STB(pgm_stb),
    .PGM_WORD(pgm_word));
  fpcq_host host (.clk(clk), .status(status), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .addr(addr), .wr_data(wr_data));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    if (n_fail == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Every launched word must have been expected, in order
  always @(negedge clk) begin
    if (pgm_stb === 1'b1) begin
      if (pq.size() == 0) chk(16'h1, 16'h0);
      else chk(pgm_word, pq.pop_front());
    end
  end

  task automatic rdc(input int p, input int off);
    logic [15:0] e;
    array_data = $urandom;
    case (mode[p])
      0: e = array_data;
      1: e = sr[15:0];
      default: e = {8'h00, qry[off-16]};
    endcase
    host.rd(p, off);
    chk(rd_valid, 1'b1);
    chk(rd_data, e);
  endtask

  task automatic wt(input bit sr0, input logic v, input int lim);
    int n;
    n = 0;
    while ((sr0 ? status[0] : busy) !== v && n < lim) begin
      @(negedge clk);
      n++;
    end
    chk(sr0 ? status[0] : busy, v);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    end_of_test();
  end

  initial begin
    void'($urandom(32'h87b2d9a3));
    rst = 1'b1;
    err_set = 8'h00;
    array_data = 16'h0;
    foreach (mode[i]) mode[i] = 0;
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    chk(status, sr[15:0]);
    for (int p = 0; p < 8; p++) rdc(p, $urandom_range(255));
    host.wr(1, 16'h70);
    mode[1] = 1;
    rdc(1, 0);
    rdc(2, 0);
    host.wr(2, 16'h98);
    mode[2] = 2;
    for (int o = 16; o < 27; o++) rdc(2, o);
    rdc(1, 5);
    host.wr(1, 16'hff);
    mode[1] = 0;
    rdc(1, 5);
    // Sticky error, then a program with a refused program and clear behind it
    err_set = 8'h10;
    @(negedge clk);
    err_set = 8'h00;
    sr = 'h90;
    chk(status, sr[15:0]);
    d = $urandom;
    pq.push_back(d);
    host.cmd2(3, 16'h40, d);
    mode[3] = 1;
    sr = 'h10;
    wt(0, 1'b1, 4);
    host.cmd2(3, 16'h40, 16'h1234);
    host.wr(7, 16'h50);
    rdc(3, 1);
    wt(0, 1'b0, 200);
    sr = 'h90;
    chk(status, sr[15:0]);
    host.wr(7, 16'h50);
    sr = 'h80;
    @(negedge clk);
    chk(status, sr[15:0]);
    // Split two-cycle command
    d = $urandom;
    pq.push_back(d);
    host.wr(4, 16'h40);
    host.wr(5, d);
    mode[4] = 1;
    mode[5] = 1;
    sr = 'h00;
    wt(0, 1'b1, 4);
    rdc(4, 0);
    rdc(5, 0);
    wt(0, 1'b0, 200);
    sr = 'h80;
    foreach (conf[i]) begin
      host.cmd2(6, 16'h60, conf[i]);
      d = $urandom;
      pq.push_back(d);
      host.cmd2(6, 16'h40, d);
      wt(0, 1'b1, 4);
      wt(0, 1'b0, 200);
    end
    // Erase, suspend, refused setups, then program and its own suspend
    host.cmd2(0, 16'h20, 16'hd0);
    wt(0, 1'b1, 4);
    host.wr(0, 16'hb0);
    wt(0, 1'b0, 20);
    host.cmd2(0, 16'h20, 16'hd0);
    host.cmd2(0, 16'hc0, 16'h5555);
    host.cmd2(0, 16'h30, 16'hd0);
    repeat (3) @(negedge clk);
    chk(busy, 1'b0);
    d = $urandom;
    pq.push_back(d);
    host.cmd2(0, 16'h40, d);
    wt(0, 1'b1, 4);
    host.wr(0, 16'hb0);
    wt(0, 1'b0, 20);
    host.cmd2(0, 16'h40, 16'h0f0f);
    repeat (3) @(negedge clk);
    chk(busy, 1'b0);
    host.wr(0, 16'hd0);
    wt(0, 1'b1, 4);
    wt(0, 1'b0, 200);
    host.wr(0, 16'hd0);
    wt(0, 1'b1, 4);
    wt(0, 1'b0, 200);
    // Factory programming: command codes pass through as data
    host.cmd2(6, 16'h30, 16'hd0);
    wt(0, 1'b1, 4);
    for (int i = 0; i < 4; i++) begin
      d = (i == 1) ? 16'hd0 : (i == 2) ? 16'h70 : 16'($urandom);
      pq.push_back(d);
      host.efp_word(6, d);
    end
    wt(1, 1'b1, 4);
    host.wr(6, 16'h1111);
    chk(busy, 1'b1);
    host.efp_word(0, 16'hffff);
    wt(0, 1'b0, 200);
    chk(status[0], 1'b0);
    chk(16'(pq.size()), 16'h0);
    repeat (5) @(negedge clk);
    end_of_test();
  end
endmodule
